/* File: logic/slm_pkg.sv */
`default_nettype none
package slm_pkg;
  // field widths of the control words
  localparam int N_W = 16;
  localparam int FRAC_W = 12;
  localparam int DIV_CODE_W = 3;
  localparam int PUMP_W = 4;
  localparam int LEVEL_W = 2;
  localparam int MON_W = 4;
  localparam int TIMER_W = 24;
  // feedback divider cap when the output divider sits in the loop
  localparam logic [7:0] FB_DIV_CAP = 8'h10;
  // pump codes
  localparam logic [3:0] PUMP_MIN = 4'h0;
  localparam logic [3:0] PUMP_FAST = 4'hf;
  // divider timer mode that arms fast-lock
  localparam logic [1:0] TIMER_MODE_FASTLOCK = 2'h1;
  // lock indicator selector codes
  localparam logic [1:0] LOCK_SEL_DIGITAL = 2'h1;
  localparam logic [1:0] LOCK_SEL_ANALOG = 2'h2;
  // locked cycles needed to set digital lock
  localparam logic [5:0] LOCK_CYCLES_FRAC = 6'h28;
  localparam logic [5:0] LOCK_CYCLES_INT = 6'h05;
  // skew windows in ns and their boundary
  localparam int PFD_SLOW_MAX_MHZ = 32;
  localparam logic [4:0] SKEW_LOCK_WIDE_NS = 5'h0a;
  localparam logic [4:0] SKEW_LOCK_FINE_NS = 5'h06;
  localparam logic [4:0] SKEW_LOCK_FAST_NS = 5'h04;
  localparam logic [4:0] SKEW_UNLOCK_SLOW_NS = 5'h0f;
  localparam logic [4:0] SKEW_UNLOCK_FAST_NS = 5'h04;
  // reset values
  localparam logic [5:0] LOCK_CNT_RST = 6'h00;
  localparam logic [TIMER_W-1:0] TIMER_RST = 24'h000000;
  localparam logic [N_W-1:0] NCNT_RST = 16'h0000;
endpackage : slm_pkg
`default_nettype wire

/* File: logic/slm_pfd_timer.sv */
`default_nettype none
// ----------------------------------------
// pfd-cycle countdown timer
// ----------------------------------------
module slm_pfd_timer (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic pfd_tick_i, // one pulse per pfd cycle
  input wire logic start_i, // restart with load value
  input wire logic [slm_pkg::TIMER_W-1:0] load_i, // cycles to run
  output logic busy_o // high while counting
);
  logic [slm_pkg::TIMER_W-1:0] count;

  // restart wins over counting so a fresh trigger reloads
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= slm_pkg::TIMER_RST;
    end else if (start_i) begin
      count <= load_i;
    end else if (pfd_tick_i && count != slm_pkg::TIMER_RST) begin
      count <= count - 24'h000001;
    end
  end

  assign busy_o = (count != slm_pkg::TIMER_RST);
endmodule : slm_pfd_timer
`default_nettype wire

/* File: logic/slm_lock_detect.sv */
`default_nettype none
// ----------------------------------------
// digital lock detect on measured skew
// ----------------------------------------
module slm_lock_detect (
  input wire logic clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic pfd_tick_i, // one pulse per pfd cycle
  input wire logic [4:0] skew_ns_i, // up/down skew of this cycle in ns
  input wire logic integer_mode_i, // lock detect kind: 1 integer
  input wire logic lock_speed_select_i, // 1 for pfd above 32 MHz
  input wire logic lock_window_precision_i, // 1 selects fine window; ignored when lock_speed_select_i is 1
  output logic locked_o // digital lock level
);
  logic [4:0] win_lock;
  logic [4:0] win_unlock;
  logic [5:0] need;
  logic [5:0] run;

  // window choice per pfd speed and precision
  always_comb begin
    if (lock_speed_select_i) begin
      win_lock = slm_pkg::SKEW_LOCK_FAST_NS;
      win_unlock = slm_pkg::SKEW_UNLOCK_FAST_NS;
    end else begin
      win_lock = lock_window_precision_i ? slm_pkg::SKEW_LOCK_FINE_NS : slm_pkg::SKEW_LOCK_WIDE_NS;
      win_unlock = slm_pkg::SKEW_UNLOCK_SLOW_NS;
    end
    need = integer_mode_i ? slm_pkg::LOCK_CYCLES_INT : slm_pkg::LOCK_CYCLES_FRAC;
  end

  // run length of in-window cycles; saturates at the target
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run <= slm_pkg::LOCK_CNT_RST;
    end else if (pfd_tick_i) begin
      if (skew_ns_i > win_lock) begin
        run <= slm_pkg::LOCK_CNT_RST;
      end else if (run < need) begin
        run <= run + 6'h01;
      end
    end
  end

  // set after the run, clear only at or past the unlock skew (hysteresis)
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      locked_o <= 1'b0;
    end else if (pfd_tick_i) begin
      if (skew_ns_i >= win_unlock && !(lock_speed_select_i && skew_ns_i <= win_lock)) begin
        locked_o <= 1'b0;
      end else if (skew_ns_i <= win_lock && run + 6'h01 >= need) begin
        locked_o <= 1'b1;
      end
    end
  end
endmodule : slm_lock_detect
`default_nettype wire

/* File: logic/slm_control.sv */
`default_nettype none
// ----------------------------------------
// synthesizer lock and mute control
// ----------------------------------------
module slm_control (
  input wire logic clk_i, // 25 MHz system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic pfd_clk_pin_i, // phase-detector clock, async pin
  input wire logic [4:0] skew_ns_i, // measured up/down skew, same domain
  input wire logic integer_mode_i, // 1 integer, 0 fractional
  input wire logic [slm_pkg::N_W-1:0] int_value_i, // integer counter value
  input wire logic [slm_pkg::FRAC_W-1:0] frac_value_i, // fractional numerator
  input wire logic [slm_pkg::FRAC_W-1:0] modulus_i, // fractional modulus
  input wire logic feedback_path_select_i, // 1 feedback from VCO
  input wire logic [2:0] output_a_divider_i, // output divider code
  input wire logic output_b_source_i, // 1 undivided VCO
  input wire logic counter_reset_i, // holds integer counter
  input wire logic lock_detect_kind_i, // 1 integer lock detect
  input wire logic zero_frac_auto_integer_i, // auto integer at zero fraction
  input wire logic [slm_pkg::PUMP_W-1:0] pump_current_code_i, // pump current code
  input wire logic [1:0] pump_linearity_i, // pump linearity code
  input wire logic pump_tristate_i, // 1 pump high impedance
  input wire logic detector_polarity_i, // 1 noninverting filter
  input wire logic [slm_pkg::MON_W-1:0] monitor_pin_select_i, // monitor function
  input wire logic [1:0] lock_indicator_i, // lock output source
  input wire logic analog_lock_i, // analog lock level, same domain
  input wire logic lock_speed_select_i, // 1 pfd above 32 MHz
  input wire logic lock_window_precision_i, // fine window
  input wire logic slip_reduce_enable_i, // cycle slip reduction
  input wire logic [1:0] divider_timer_mode_i, // timer mode
  input wire logic [11:0] timer_clock_divisor_i, // timer divisor
  input wire logic vco_autoselect_done_i, // pulse when autoselect ends
  input wire logic output_a_enable_i, // output A enable bit
  input wire logic output_b_enable_i, // output B enable bit
  input wire logic outputs_enable_pin_i, // enable pin, async
  input wire logic [slm_pkg::LEVEL_W-1:0] output_a_level_i, // output A power code
  input wire logic [slm_pkg::LEVEL_W-1:0] output_b_level_i, // output B power code
  input wire logic unlock_output_mute_i, // mute while unlocked
  input wire logic relock_enable_delay_i, // delay re-enable after lock
  output logic effective_integer_o, // divider runs integer
  output logic [4:0] loop_divide_o, // extra feedback divide factor
  output logic [7:0] output_a_ratio_o, // output A division ratio
  output logic output_b_from_vco_o, // output B undivided
  output logic [slm_pkg::N_W-1:0] int_counter_o, // integer counter state
  output logic [4:0] pump_scale_o, // pump current multiple
  output logic pump_tristate_o, // pump high impedance
  output logic detector_polarity_o, // polarity to detector
  output logic [slm_pkg::MON_W-1:0] monitor_select_o, // monitor selector
  output logic lock_o, // lock output level
  output logic lock_oe_o, // lock pin driven
  output logic digital_lock_o, // digital lock level
  output logic fastlock_ground_pin_o, // ground fast-lock pin
  output logic fastlock_ground_pin_oe_o, // fast-lock pin driven
  output logic output_a_on_o, // output A enabled
  output logic output_b_on_o, // output B enabled
  output logic [slm_pkg::LEVEL_W-1:0] output_a_level_o, // output A level
  output logic [slm_pkg::LEVEL_W-1:0] output_b_level_o, // output B level
  output logic config_error_o // host broke a programming duty
);
  // ----------------------------------------
  // pin synchronisers and pfd tick
  // ----------------------------------------
  logic pfd_meta, pfd_sync, pfd_prev;
  logic en_meta, en_sync;
  logic pfd_tick;

  // two flops each; edge detect only looks at the second
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pfd_meta <= 1'b0;
      pfd_sync <= 1'b0;
      pfd_prev <= 1'b0;
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else begin
      pfd_meta <= pfd_clk_pin_i;
      pfd_sync <= pfd_meta;
      pfd_prev <= pfd_sync;
      en_meta <= outputs_enable_pin_i;
      en_sync <= en_meta;
    end
  end

  // limitation: pfd clock must stay well below half of 25 MHz to be counted
  assign pfd_tick = pfd_sync & ~pfd_prev;

  // ----------------------------------------
  // mode and divider relationships
  // ----------------------------------------
  logic next_eff_int;
  logic [7:0] next_a_ratio;
  logic [4:0] next_loop_div;

  always_comb begin
    next_eff_int = integer_mode_i | (zero_frac_auto_integer_i && frac_value_i == 12'h000);
    next_a_ratio = 8'h01 << output_a_divider_i;
    if (feedback_path_select_i) begin
      next_loop_div = 5'h01;
    end else if (next_a_ratio <= slm_pkg::FB_DIV_CAP) begin
      next_loop_div = next_a_ratio[4:0];
    end else begin
      next_loop_div = slm_pkg::FB_DIV_CAP[4:0];
    end
  end

  // divider settings registered so data outputs come from flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      effective_integer_o <= 1'b0;
      output_a_ratio_o <= 8'h01;
      loop_divide_o <= 5'h01;
      output_b_from_vco_o <= 1'b0;
    end else begin
      effective_integer_o <= next_eff_int;
      output_a_ratio_o <= next_a_ratio;
      loop_divide_o <= next_loop_div;
      output_b_from_vco_o <= output_b_source_i;
    end
  end

  // ----------------------------------------
  // integer feedback counter
  // ----------------------------------------
  // counts pfd cycles from 0 to one below the programmed value, then wraps to 0; held at 0 while reset bit is set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_counter_o <= slm_pkg::NCNT_RST;
    end else if (counter_reset_i) begin
      int_counter_o <= slm_pkg::NCNT_RST;
    end else if (pfd_tick) begin
      int_counter_o <= (int_counter_o + 16'h0001 >= int_value_i) ? slm_pkg::NCNT_RST : int_counter_o + 16'h0001;
    end
  end

  // ----------------------------------------
  // programming duty check
  // ----------------------------------------
  // flags out-of-range host values; reported, never corrected
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      config_error_o <= 1'b0;
    end else begin
      config_error_o <= (integer_mode_i && int_value_i < 16'h0010)
        || (!integer_mode_i && (int_value_i < 16'h0013 || int_value_i > 16'h0ffb))
        || modulus_i < 12'h002
        || frac_value_i >= modulus_i
        || (integer_mode_i && pump_linearity_i != 2'h0)
        || (integer_mode_i != lock_detect_kind_i)
        || (slip_reduce_enable_i && pump_current_code_i != slm_pkg::PUMP_MIN);
    end
  end

  // ----------------------------------------
  // digital lock detect
  // ----------------------------------------
  logic dig_lock;

  slm_lock_detect u_lock (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pfd_tick_i(pfd_tick),
    .skew_ns_i(skew_ns_i),
    .integer_mode_i(lock_detect_kind_i),
    .lock_speed_select_i(lock_speed_select_i),
    .lock_window_precision_i(lock_window_precision_i),
    .locked_o(dig_lock)
  );

  assign digital_lock_o = dig_lock;

  // ----------------------------------------
  // fast-lock and relock delay timers
  // ----------------------------------------
  logic [slm_pkg::TIMER_W-1:0] timer_load;
  logic fast_armed, fast_start, fast_busy;
  logic lock_prev, relock_start, mute_busy;

  // timeout in pfd cycles is modulus times divisor
  assign timer_load = {12'h000, modulus_i} * {12'h000, timer_clock_divisor_i};
  assign fast_armed = pump_current_code_i == slm_pkg::PUMP_MIN
    && divider_timer_mode_i == slm_pkg::TIMER_MODE_FASTLOCK;
  assign fast_start = fast_armed & vco_autoselect_done_i;

  slm_pfd_timer u_fast (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pfd_tick_i(pfd_tick),
    .start_i(fast_start),
    .load_i(timer_load),
    .busy_o(fast_busy)
  );

  // lock level a cycle late
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_prev <= 1'b0;
    end else begin
      lock_prev <= dig_lock;
    end
  end

  // each new lock edge restarts the delay
  assign relock_start = dig_lock & ~lock_prev & relock_enable_delay_i;

  slm_pfd_timer u_mute (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pfd_tick_i(pfd_tick),
    .start_i(relock_start),
    .load_i(timer_load),
    .busy_o(mute_busy)
  );

  // ----------------------------------------
  // charge pump and detector
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_scale_o <= 5'h01;
      pump_tristate_o <= 1'b0;
      detector_polarity_o <= 1'b0;
      monitor_select_o <= 4'h0;
      fastlock_ground_pin_o <= 1'b0;
      fastlock_ground_pin_oe_o <= 1'b0;
    end else begin
      pump_scale_o <= {1'b0, (fast_busy ? slm_pkg::PUMP_FAST : pump_current_code_i)}
        + 5'h01;
      pump_tristate_o <= pump_tristate_i;
      detector_polarity_o <= detector_polarity_i;
      monitor_select_o <= monitor_pin_select_i;
      fastlock_ground_pin_o <= 1'b0; // pin only ever pulled to ground
      fastlock_ground_pin_oe_o <= fast_busy;
    end
  end

  // ----------------------------------------
  // lock output and output gating
  // ----------------------------------------
  logic mute;

  // delay keeps outputs off through lock flicker during overshoot
  assign mute = unlock_output_mute_i
    && (!dig_lock || (relock_enable_delay_i && (mute_busy || relock_start)));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_o <= 1'b0;
      lock_oe_o <= 1'b0;
      output_a_on_o <= 1'b0;
      output_b_on_o <= 1'b0;
      output_a_level_o <= 2'h0;
      output_b_level_o <= 2'h0;
    end else begin
      // analog mode is open drain: drive low only when unlocked
      case (lock_indicator_i)
        slm_pkg::LOCK_SEL_DIGITAL: begin
          lock_o <= dig_lock;
          lock_oe_o <= 1'b1;
        end
        slm_pkg::LOCK_SEL_ANALOG: begin
          lock_o <= 1'b0;
          lock_oe_o <= ~analog_lock_i;
        end
        default: begin
          lock_o <= 1'b0;
          lock_oe_o <= 1'b1;
        end
      endcase
      output_a_on_o <= output_a_enable_i & en_sync & ~mute;
      output_b_on_o <= output_b_enable_i & en_sync & ~mute;
      output_a_level_o <= output_a_level_i;
      output_b_level_o <= output_b_level_i;
    end
  end
endmodule : slm_control
`default_nettype wire

/* File: dv/slm_control_properties.sv */
`default_nettype none
// ----------------------------------------
// port relations of slm_control
// ----------------------------------------
module slm_control_props (
  input wire logic clk_i, nrst_i, integer_mode_i, zero_frac_auto_integer_i, // clock, reset, mode bits
  input wire logic [slm_pkg::FRAC_W-1:0] frac_value_i, // numerator
  input wire logic feedback_path_select_i, output_b_source_i, counter_reset_i, // path bits
  input wire logic [2:0] output_a_divider_i, // divider code
  input wire logic [slm_pkg::PUMP_W-1:0] pump_current_code_i, // pump code
  input wire logic pump_tristate_i, analog_lock_i, unlock_output_mute_i, // loose bits
  input wire logic [1:0] lock_indicator_i, // lock selector
  input wire logic effective_integer_o, output_b_from_vco_o, pump_tristate_o, lock_o, lock_oe_o, // levels
  input wire logic digital_lock_o, fastlock_ground_pin_o, fastlock_ground_pin_oe_o, // lock, fast-lock
  input wire logic output_a_on_o, output_b_on_o, // output gates
  input wire logic [4:0] loop_divide_o, pump_scale_o, // divide, pump
  input wire logic [7:0] output_a_ratio_o, // ratio
  input wire logic [slm_pkg::N_W-1:0] int_counter_o // counter
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // first edge after release shows reset values; skipped
  a_ratio_pow_two: assert property ($past(nrst_i) |-> output_a_ratio_o == (8'h01 << $past(output_a_divider_i)))
    else $error("output A ratio wrong");
  a_loop_divide_cap: assert property ($past(nrst_i) |-> loop_divide_o == ($past(feedback_path_select_i) ? 5'h01 :
    ($past(output_a_divider_i) > 3'h4 ? 5'h10 : 5'h01 << $past(output_a_divider_i)))) else $error("loop divide wrong");
  a_b_source: assert property ($past(nrst_i) |-> output_b_from_vco_o == $past(output_b_source_i))
    else $error("output B source wrong");
  a_pump_scale: assert property ($past(nrst_i) && !fastlock_ground_pin_oe_o |->
    pump_scale_o == {1'b0, $past(pump_current_code_i)} + 5'h01) else $error("pump scale wrong");
  a_fast_pump: assert property (fastlock_ground_pin_oe_o |-> pump_scale_o == 5'h10 && !fastlock_ground_pin_o)
    else $error("fast-lock pump or pin wrong");
  a_tristate_follow: assert property ($past(nrst_i) |-> pump_tristate_o == $past(pump_tristate_i))
    else $error("pump tristate wrong");
  a_auto_integer: assert property ($past(nrst_i) |-> effective_integer_o == ($past(integer_mode_i) ||
    ($past(zero_frac_auto_integer_i) && $past(frac_value_i) == '0))) else $error("integer fallback wrong");
  a_lock_route: assert property ($past(nrst_i) |->
    lock_o == ($past(lock_indicator_i) == 2'h1 && $past(digital_lock_o))) else $error("lock route wrong");
  a_analog_drain: assert property ($past(nrst_i) && $past(lock_indicator_i) == 2'h2 |->
    lock_oe_o == !$past(analog_lock_i)) else $error("open drain lock wrong");
  a_unlock_mute: assert property ($past(nrst_i) && $past(unlock_output_mute_i) && !$past(digital_lock_o) |->
    !output_a_on_o && !output_b_on_o) else $error("outputs not muted");
  a_counter_hold: assert property (counter_reset_i ##1 counter_reset_i |-> int_counter_o == '0)
    else $error("counter not held");
  c_fast_lock: cover property ($rose(fastlock_ground_pin_oe_o));
  c_lock_set: cover property ($rose(digital_lock_o));
  c_relock: cover property (unlock_output_mute_i && $rose(output_a_on_o));
endmodule : slm_control_props

bind slm_control slm_control_props u_props (.clk_i, .nrst_i, .integer_mode_i, .zero_frac_auto_integer_i,
  .frac_value_i, .feedback_path_select_i, .output_b_source_i, .counter_reset_i, .output_a_divider_i,
  .pump_current_code_i, .pump_tristate_i, .analog_lock_i, .unlock_output_mute_i, .lock_indicator_i,
  .effective_integer_o, .output_b_from_vco_o, .pump_tristate_o, .lock_o, .lock_oe_o, .digital_lock_o,
  .fastlock_ground_pin_o, .fastlock_ground_pin_oe_o, .output_a_on_o, .output_b_on_o, .loop_divide_o,
  .pump_scale_o, .output_a_ratio_o, .int_counter_o);
`default_nettype wire

/* File: dv/slm_loop_model.sv */
`default_nettype none
// ----------------------------------------
// loop side: detector clock, skew, analog lock
// ----------------------------------------
module slm_loop_model #(
  parameter int HALF_NS = 200 // half period of the detector clock
) (
  input wire logic [4:0] skew_set_i, // skew the loop shows
  input wire logic lock_set_i, // analog lock level
  output logic pfd_clk_o, // detector clock pin
  output logic [4:0] skew_ns_o, // measured skew
  output logic analog_lock_o // analog lock level
);
  timeunit 1ns;
  timeprecision 1ps;
  // runs free like the reference; offset keeps edges off clk edges
  initial begin
    pfd_clk_o = 1'b0;
    #7;
    forever #(HALF_NS) pfd_clk_o = ~pfd_clk_o;
  end
  // skew and analog lock are levels of the loop's present state
  assign skew_ns_o = skew_set_i;
  assign analog_lock_o = lock_set_i;
endmodule : slm_loop_model
`default_nettype wire

/* File: dv/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i = 1'b0, nrst_i = 1'b0, int_mode = 1'b0, kind = 1'b0, fb = 1'b1, bsrc = 1'b0, crst = 1'b0;
  logic f0i = 1'b0, tri_i = 1'b0, pol = 1'b1, lspd = 1'b0, lprec = 1'b0, slip = 1'b0, done = 1'b0, alk = 1'b0;
  logic aen = 1'b1, ben = 1'b1, epin = 1'b1, mute = 1'b0, rdel = 1'b0;
  logic [15:0] nval = 16'h0064;
  logic [11:0] frac = 12'h005, modv = 12'h064, timer_clock_divisor = 12'h001;
  logic [2:0] output_a_divider = 3'h0;
  logic [3:0] pump = 4'h0, mon = 4'h0;
  logic [1:0] lin = 2'h0, lsel = 2'h1, tmode = 2'h0, alv = 2'h0, blv = 2'h0;
  logic [4:0] skw_set = 5'h14;
  wire logic pfd, alk_o;
  wire logic [4:0] skw;
  logic eff, bvco, tri_o, pol_o, lk, lk_oe, dlk, sw, sw_oe, aon, bon, cerr;
  logic [4:0] ldiv, psc;
  logic [7:0] rat;
  logic [15:0] cnt;
  logic [3:0] mon_o;
  logic [1:0] alv_o, blv_o;
  int n_fail = 0, num_checks = 0, cycles = 0;

  slm_loop_model #(.HALF_NS(200)) u_loop (.skew_set_i(skw_set), .lock_set_i(alk), .pfd_clk_o(pfd),
    .skew_ns_o(skw), .analog_lock_o(alk_o));
  slm_control DUT (.clk_i(clk_i), .nrst_i(nrst_i), .pfd_clk_pin_i(pfd), .skew_ns_i(skw), .integer_mode_i(int_mode),
    .int_value_i(nval), .frac_value_i(frac), .modulus_i(modv), .feedback_path_select_i(fb),
    .output_a_divider_i(output_a_divider), .output_b_source_i(bsrc), .counter_reset_i(crst), .lock_detect_kind_i(kind),
    .zero_frac_auto_integer_i(f0i), .pump_current_code_i(pump), .pump_linearity_i(lin), .pump_tristate_i(tri_i),
    .detector_polarity_i(pol), .monitor_pin_select_i(mon), .lock_indicator_i(lsel), .analog_lock_i(alk_o),
    .lock_speed_select_i(lspd), .lock_window_precision_i(lprec), .slip_reduce_enable_i(slip),
    .divider_timer_mode_i(tmode), .timer_clock_divisor_i(timer_clock_divisor), .vco_autoselect_done_i(done),
    .output_a_enable_i(aen), .output_b_enable_i(ben), .outputs_enable_pin_i(epin), .output_a_level_i(alv),
    .output_b_level_i(blv), .unlock_output_mute_i(mute), .relock_enable_delay_i(rdel), .effective_integer_o(eff),
    .loop_divide_o(ldiv), .output_a_ratio_o(rat), .output_b_from_vco_o(bvco), .int_counter_o(cnt),
    .pump_scale_o(psc), .pump_tristate_o(tri_o), .detector_polarity_o(pol_o), .monitor_select_o(mon_o),
    .lock_o(lk), .lock_oe_o(lk_oe), .digital_lock_o(dlk), .fastlock_ground_pin_o(sw),
    .fastlock_ground_pin_oe_o(sw_oe), .output_a_on_o(aon), .output_b_on_o(bon), .output_a_level_o(alv_o),
    .output_b_level_o(blv_o), .config_error_o(cerr));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 25 MHz system clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // hang guard, far above the real run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  // n detector rises, then sync, tick and lock settle
  task automatic rises(input int n);
    repeat (n) @(posedge pfd);
    cyc(6);
  endtask : rises
  task automatic pulse_done();
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(1);
  endtask : pulse_done
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_static();
    for (int c = 0; c < 8; c++) begin
      output_a_divider = 3'(c);
      fb = c[0];
      bsrc = c[1];
      pump = 4'(c * 2);
      tri_i = c[0];
      pol = c[1];
      mon = 4'(c + 8);
      alv = 2'(c);
      blv = 2'(~c);
      cyc(2);
      check("a_ratio", rat, 8'h01 << c);
      check("loop_div", ldiv, c[0] ? 5'h01 : (c > 4 ? 5'h10 : 5'h01 << c));
      check("b_vco", bvco, bsrc);
      check("pump", psc, 5'(c * 2 + 1));
      check("tri_pol", {tri_o, pol_o}, {tri_i, pol});
      check("monitor", mon_o, mon);
      check("levels", {alv_o, blv_o}, {alv, blv});
    end
    pump = 4'h0;
    lsel = 2'h2;
    alk = 1'b1;
    cyc(2);
    check("od_off", {lk, lk_oe}, 2'b00);
    alk = 1'b0;
    cyc(2);
    check("od_low", {lk, lk_oe}, 2'b01);
    {lsel, alk} = 3'b111;
    cyc(2);
    check("ld_off", {lk, lk_oe}, 2'b01);
    lsel = 2'h1;
    $display("t_static done");
  endtask : t_static
  task automatic t_mode();
    for (int k = 0; k < 8; k++) begin
      int_mode = k[0];
      kind = k[0];
      f0i = k[1];
      frac = k[2] ? 12'h000 : 12'h005;
      lin = 2'(k[1]);
      cyc(2);
      check("eff_int", eff, k[0] | (k[1] & k[2]));
      check("lin_int", cerr, k[0] & k[1]);
    end
    lin = 2'h0;
    int_mode = 1'b0;
    kind = 1'b0;
    f0i = 1'b0;
    frac = 12'h005;
    $display("t_mode done");
  endtask : t_mode
  task automatic cfg(input logic [11:0] m, f, input logic [15:0] n, input logic s, k, input logic [3:0] p, input e);
    modv = m;
    frac = f;
    nval = n;
    slip = s;
    kind = k;
    pump = p;
    cyc(2);
    check("cfg_err", cerr, e);
  endtask : cfg
  task automatic t_refuse();
    cfg(12'h064, 12'h005, 16'h0064, 1'b0, 1'b0, 4'h0, 1'b0);
    cfg(12'h001, 12'h000, 16'h0064, 1'b0, 1'b0, 4'h0, 1'b1);
    cfg(12'h064, 12'h064, 16'h0064, 1'b0, 1'b0, 4'h0, 1'b1);
    cfg(12'h064, 12'h005, 16'h0ffc, 1'b0, 1'b0, 4'h0, 1'b1);
    cfg(12'h064, 12'h005, 16'h0064, 1'b1, 1'b0, 4'h1, 1'b1);
    cfg(12'h064, 12'h005, 16'h0064, 1'b1, 1'b0, 4'h0, 1'b0);
    cfg(12'h064, 12'h005, 16'h0064, 1'b0, 1'b1, 4'h0, 1'b1);
    kind = 1'b0;
    slip = 1'b0;
    crst = 1'b1;
    cyc(30);
    check("cnt_hold", cnt, 16'h0000);
    crst = 1'b0;
    rises(3);
    check("cnt_run", cnt != 16'h0000, 1'b1);
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_lock(input logic imode, input int want);
    int n;
    int_mode = imode;
    kind = imode;
    skw_set = 5'h14;
    rises(2);
    check("lock_idle", dlk, 1'b0);
    @(posedge pfd);
    @(negedge clk_i);
    skw_set = 5'h0a;
    n = 1;
    cyc(5);
    while (dlk !== 1'b1 && n < 60) begin
      rises(1);
      n++;
    end
    check("lock_cycles", n, want);
    check("lock_pin", lk, 1'b1);
    skw_set = 5'h0f;
    rises(1);
    check("unlock", dlk, 1'b0);
    lprec = 1'b1;
    skw_set = 5'h08;
    rises(want + 3);
    check("fine_window", dlk, 1'b0);
    lspd = 1'b1;
    skw_set = 5'h04;
    rises(want + 2);
    check("fast_lock", dlk, 1'b1);
    skw_set = 5'h05;
    rises(1);
    check("fast_unlock", dlk, 1'b0);
    lspd = 1'b0;
    lprec = 1'b0;
    $display("t_lock done");
  endtask : t_lock
  task automatic t_mute();
    mute = 1'b1;
    skw_set = 5'h14;
    rises(2);
    check("mute_off", {aon, bon}, 2'b00);
    skw_set = 5'h0a;
    rises(6);
    check("mute_on", {aon, bon}, 2'b11);
    epin = 1'b0;
    cyc(4);
    check("pin_off", {aon, bon}, 2'b00);
    epin = 1'b1;
    aen = 1'b0;
    cyc(4);
    check("a_bit", {aon, bon}, 2'b01);
    aen = 1'b1;
    rdel = 1'b1;
    modv = 12'h003;
    timer_clock_divisor = 12'h002;
    skw_set = 5'h14;
    rises(2);
    skw_set = 5'h0a;
    rises(7);
    check("delay_hold", aon, 1'b0);
    rises(6);
    check("delay_done", aon, 1'b1);
    rdel = 1'b0;
    mute = 1'b0;
    $display("t_mute done");
  endtask : t_mute
  // lock output is not judged while fast-lock follows autoselect
  task automatic t_fast();
    tmode = 2'h1;
    pulse_done();
    check("fast_on", {sw_oe, sw, psc}, {2'b10, 5'h10});
    rises(3);
    pulse_done();
    rises(4);
    check("fast_restart", sw_oe, 1'b1);
    rises(4);
    check("fast_end", {sw_oe, psc}, {1'b0, 5'h01});
    $display("t_fast done");
  endtask : t_fast
  // ----------------------------------------
  // run
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk_i);
    check("rst_vals", {rat, ldiv, psc, lk, dlk, aon, bon, sw_oe}, {8'h01, 5'h01, 5'h01, 5'h00});
    nrst_i = 1'b1;
    cyc(2);
    t_static();
    t_mode();
    t_refuse();
    t_lock(1'b0, 40);
    t_lock(1'b1, 5);
    t_mute();
    t_fast();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
